// *** logic/ufs_port.sv ***
// Controller-side port driving an external full/low-speed serial USB transceiver.
`timescale 1ns/1ps

module ufs_port #(
    parameter int BIT_DIV = ufs_pkg::UFS_BIT_CYCLES,
    parameter int FIFO_DEPTH = ufs_pkg::UFS_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Configuration
    input wire ufs_pkg::ufs_mode_t serial_mode,
    input wire ufs_pkg::ufs_map_t bus_map,
    input wire logic use_data_bus,
    // Transmit symbol stream
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic tx_last,
    input wire logic tx_a,
    input wire logic tx_b,
    // Status and received line state
    output logic tx_busy,
    output logic rx_dat,
    output logic rx_se0,
    output logic rx_dp,
    output logic rx_dm,
    output logic phy_int,
    // Legacy serial pins
    output logic transmit_output_enable_n,
    input wire logic shared_data_or_plus_level_pin_in,
    output logic shared_data_or_plus_level_pin_out,
    output logic shared_data_or_plus_level_pin_oe,
    input wire logic shared_se0_or_minus_level_pin_in,
    output logic shared_se0_or_minus_level_pin_out,
    output logic shared_se0_or_minus_level_pin_oe,
    input wire logic buffered_plus_line_input,
    input wire logic buffered_minus_line_input,
    input wire logic recv_diff_input,
    // Eight-bit transceiver data bus
    input wire logic [7:0] phy_data_in,
    output logic [7:0] phy_data_out,
    output logic [7:0] phy_data_oe
);
    import ufs_pkg::*;

    // ==========================================================
    // Symbol FIFO
    // ==========================================================
    ufs_stream_if #(.WIDTH(UFS_SYM_W)) in_if ();
    ufs_stream_if #(.WIDTH(UFS_SYM_W)) out_if ();

    assign in_if.valid = tx_valid;
    assign in_if.data = {tx_last, tx_a, tx_b};
    assign tx_ready = in_if.ready;

    ufs_fifo #(.WIDTH(UFS_SYM_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .fill(in_if),
        .drain(out_if)
    );

    // ==========================================================
    // Bit-rate divider
    // ==========================================================
    logic [UFS_DIV_W-1:0] div;
    logic [UFS_DIV_W-1:0] next_div;
    logic tick;

    always_comb begin
        tick = (div == UFS_DIV_W'(BIT_DIV - 1));
        next_div = tick ? '0 : div + UFS_DIV_W'(1);
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            div <= '0;
        end else begin
            div <= next_div;
        end
    end

    // ==========================================================
    // Transmit sequencer and configuration latch
    // ==========================================================
    ufs_state_t state;
    ufs_state_t next_state;
    logic [UFS_SYM_W-1:0] sym;
    logic [UFS_SYM_W-1:0] next_sym;
    ufs_mode_t mode;
    ufs_mode_t next_mode;
    ufs_map_t map;
    ufs_map_t next_map;
    logic bus_sel;
    logic next_bus_sel;
    logic pop;

    always_comb begin
        next_state = state;
        next_sym = sym;
        next_mode = mode;
        next_map = map;
        next_bus_sel = bus_sel;
        pop = 1'b0;
        case (state)
            UFS_ST_IDLE: begin
                // Configuration follows the inputs only while nothing is driven.
                next_mode = serial_mode;
                next_map = bus_map;
                next_bus_sel = use_data_bus;
                if (tick && out_if.valid) begin
                    pop = 1'b1;
                    next_sym = out_if.data;
                    next_state = UFS_ST_SEND;
                end
            end
            UFS_ST_SEND: begin
                if (tick) begin
                    if (!sym[UFS_SYM_LAST] && out_if.valid) begin
                        pop = 1'b1;
                        next_sym = out_if.data;
                    end else begin
                        // A packet end or an underrun closes with one idle bit.
                        next_sym = UFS_SYM_IDLE;
                        next_state = UFS_ST_DONE;
                    end
                end
            end
            UFS_ST_DONE: begin
                if (tick) begin
                    next_state = UFS_ST_IDLE;
                end
            end
            default: begin
                next_state = UFS_ST_IDLE;
            end
        endcase
    end

    assign out_if.ready = pop;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state <= UFS_ST_IDLE;
            sym <= UFS_SYM_RESET;
            mode <= UFS_DATA_AND_SINGLE_ENDED_ZERO_MODE_BIDIR;
            map <= UFS_MAP_6PIN;
            bus_sel <= 1'b0;
        end else begin
            state <= next_state;
            sym <= next_sym;
            mode <= next_mode;
            map <= next_map;
            bus_sel <= next_bus_sel;
        end
    end

    // ==========================================================
    // Pin drive and receive sampling
    // ==========================================================
    logic driving;
    logic level_mode;
    logic tx_dat;
    logic tx_se0;
    logic next_busy;
    logic next_txoe_n;
    logic next_p_out;
    logic next_p_oe;
    logic next_m_out;
    logic next_m_oe;
    logic [7:0] next_bus_out;
    logic [7:0] next_bus_oe;
    logic next_rx_dat;
    logic next_rx_se0;
    logic next_rx_dp;
    logic next_rx_dm;
    logic next_int;

    always_comb begin
        // Only legacy serial signalling exists; no ULPI serial entry or exit.
        driving = (next_state != UFS_ST_IDLE);
        level_mode = (mode == UFS_LEVEL_BIDIR) || (mode == UFS_LEVEL_UNI);
        tx_dat = next_sym[UFS_SYM_A];
        // The bus speaks data/SE0; a level pair both low is an SE0.
        tx_se0 = level_mode ? !next_sym[UFS_SYM_A] && !next_sym[UFS_SYM_B] : next_sym[UFS_SYM_B];
        next_busy = driving;

        // Legacy pins, unused when the data bus is selected.
        next_txoe_n = !(driving && !bus_sel);
        next_p_out = next_sym[UFS_SYM_A];
        next_m_out = next_sym[UFS_SYM_B];
        case (mode)
            UFS_DATA_AND_SINGLE_ENDED_ZERO_MODE_UNI, UFS_LEVEL_UNI: begin
                next_p_oe = !bus_sel;
                next_m_oe = !bus_sel;
            end
            default: begin
                next_p_oe = !next_txoe_n;
                next_m_oe = !next_txoe_n;
            end
        endcase

        // Data bus map.
        next_bus_out = UFS_BUS_RESET;
        next_bus_oe = UFS_BUS_RESET;
        if (bus_sel) begin
            next_bus_out[UFS_BIT_TXEN] = driving;
            next_bus_out[UFS_BIT_DAT] = tx_dat;
            next_bus_out[UFS_BIT_SE0] = tx_se0;
            next_bus_oe[UFS_BIT_TXEN] = 1'b1;
            if (map == UFS_MAP_6PIN) begin
                next_bus_oe[UFS_BIT_DAT] = 1'b1;
                next_bus_oe[UFS_BIT_SE0] = 1'b1;
            end else begin
                next_bus_oe[UFS_BIT_DAT] = driving;
                next_bus_oe[UFS_BIT_SE0] = driving;
            end
        end

        // Receive state is captured only while the line is not driven.
        next_rx_dat = rx_dat;
        next_rx_se0 = rx_se0;
        next_rx_dp = rx_dp;
        next_rx_dm = rx_dm;
        next_int = bus_sel && phy_data_in[UFS_BIT_INT];
        if (state == UFS_ST_IDLE) begin
            if (bus_sel) begin
                if (map == UFS_MAP_6PIN) begin
                    // Bit 7 is reserved and never looked at.
                    next_rx_dp = phy_data_in[UFS_BIT_DP];
                    next_rx_dm = phy_data_in[UFS_BIT_DM];
                    next_rx_dat = phy_data_in[UFS_BIT_RCV];
                    next_rx_se0 = !phy_data_in[UFS_BIT_DP] && !phy_data_in[UFS_BIT_DM];
                end else begin
                    next_rx_dat = phy_data_in[UFS_BIT_DAT];
                    next_rx_se0 = phy_data_in[UFS_BIT_SE0];
                end
            end else begin
                case (mode)
                    UFS_DATA_AND_SINGLE_ENDED_ZERO_MODE_BIDIR: begin
                        next_rx_dat = shared_data_or_plus_level_pin_in;
                        next_rx_se0 = shared_se0_or_minus_level_pin_in;
                    end
                    UFS_LEVEL_BIDIR: begin
                        next_rx_dp = shared_data_or_plus_level_pin_in;
                        next_rx_dm = shared_se0_or_minus_level_pin_in;
                        next_rx_dat = recv_diff_input;
                        next_rx_se0 = !shared_data_or_plus_level_pin_in && !shared_se0_or_minus_level_pin_in;
                    end
                    default: begin
                        next_rx_dp = buffered_plus_line_input;
                        next_rx_dm = buffered_minus_line_input;
                        next_rx_dat = recv_diff_input;
                        next_rx_se0 = !buffered_plus_line_input && !buffered_minus_line_input;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            tx_busy <= 1'b0;
            transmit_output_enable_n <= 1'b1;
            shared_data_or_plus_level_pin_out <= 1'b0;
            shared_data_or_plus_level_pin_oe <= 1'b0;
            shared_se0_or_minus_level_pin_out <= 1'b0;
            shared_se0_or_minus_level_pin_oe <= 1'b0;
            phy_data_out <= UFS_BUS_RESET;
            phy_data_oe <= UFS_BUS_RESET;
            rx_dat <= 1'b0;
            rx_se0 <= 1'b0;
            rx_dp <= 1'b0;
            rx_dm <= 1'b0;
            phy_int <= 1'b0;
        end else begin
            tx_busy <= next_busy;
            transmit_output_enable_n <= next_txoe_n;
            shared_data_or_plus_level_pin_out <= next_p_out;
            shared_data_or_plus_level_pin_oe <= next_p_oe;
            shared_se0_or_minus_level_pin_out <= next_m_out;
            shared_se0_or_minus_level_pin_oe <= next_m_oe;
            phy_data_out <= next_bus_out;
            phy_data_oe <= next_bus_oe;
            rx_dat <= next_rx_dat;
            rx_se0 <= next_rx_se0;
            rx_dp <= next_rx_dp;
            rx_dm <= next_rx_dm;
            phy_int <= next_int;
        end
    end
endmodule // ufs_port

// *** inc/ufs_pkg.sv ***
// Package of constants and types for the full/low-speed serial transceiver port.
package ufs_pkg;

    // ==========================================================
    // Port modes, bus maps and transmit states
    // ==========================================================
    typedef enum logic [1:0] {
        UFS_DATA_AND_SINGLE_ENDED_ZERO_MODE_BIDIR = 2'h0,
        UFS_DATA_AND_SINGLE_ENDED_ZERO_MODE_UNI = 2'h1,
        UFS_LEVEL_BIDIR = 2'h2,
        UFS_LEVEL_UNI = 2'h3
    } ufs_mode_t;

    typedef enum logic {
        UFS_MAP_6PIN = 1'h0,
        UFS_MAP_3PIN = 1'h1
    } ufs_map_t;

    typedef enum logic [1:0] {
        UFS_ST_IDLE = 2'h0,
        UFS_ST_SEND = 2'h1,
        UFS_ST_DONE = 2'h3
    } ufs_state_t;

    // ==========================================================
    // Symbol layout: {last, a, b}
    // ==========================================================
    localparam int UFS_SYM_W = 3;
    localparam int UFS_SYM_LAST = 2;
    localparam int UFS_SYM_A = 1;
    localparam int UFS_SYM_B = 0;
    localparam int UFS_FIFO_DEPTH = 8;

    // ==========================================================
    // Data bus bit positions
    // ==========================================================
    localparam int UFS_BIT_TXEN = 0;
    localparam int UFS_BIT_DAT = 1;
    localparam int UFS_BIT_SE0 = 2;
    localparam int UFS_BIT_INT = 3;
    localparam int UFS_BIT_DP = 4;
    localparam int UFS_BIT_DM = 5;
    localparam int UFS_BIT_RCV = 6;

    // ==========================================================
    // Timing: full-speed bit time and the system clock period
    // ==========================================================
    localparam int UFS_FS_BIT_PS = 83333;
    localparam int UFS_CLK_PS = 10000;
    localparam int UFS_BIT_CYCLES = (UFS_FS_BIT_PS / UFS_CLK_PS < 1) ? 1 : UFS_FS_BIT_PS / UFS_CLK_PS;
    localparam int UFS_DIV_W = 16;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] UFS_BUS_RESET = 8'h00;
    localparam logic [UFS_SYM_W-1:0] UFS_SYM_RESET = 3'h0;
    // Idle J level: data high / plus line high, no SE0.
    localparam logic [UFS_SYM_W-1:0] UFS_SYM_IDLE = 3'h2;

endpackage

// *** inc/ufs_stream_if.sv ***
// Valid/ready stream carrier between the port's own modules.
`timescale 1ns/1ps
interface ufs_stream_if #(
    parameter int WIDTH = 3
);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// *** logic/ufs_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module ufs_fifo #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Streams
    ufs_stream_if.snk fill,
    ufs_stream_if.src drain
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] next_wr_ptr;
    logic [AW:0] next_rd_ptr;
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign empty = (wr_ptr == rd_ptr);
    assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
    assign fill.ready = !full;
    assign drain.valid = !empty;
    assign drain.data = mem[rd_ptr[AW-1:0]];
    assign push = fill.valid && !full;
    assign pop = drain.ready && !empty;

    always_comb begin
        next_wr_ptr = push ? wr_ptr + (AW+1)'(1) : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + (AW+1)'(1) : rd_ptr;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // Storage has no reset; only entries between the pointers are ever read.
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= fill.data;
        end
    end
endmodule // ufs_fifo

// *** testbench/ufs_port_assertions.sv ***
// Assertion checker for the serial transceiver port.
`timescale 1ns/1ps
module ufs_port_chk #(
    parameter int BIT_DIV = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Observed outputs and inputs
    input wire logic tx_busy,
    input wire logic tx_ready,
    input wire logic phy_int,
    input wire logic transmit_output_enable_n,
    input wire logic shared_data_or_plus_level_pin_out,
    input wire logic shared_data_or_plus_level_pin_oe,
    input wire logic shared_se0_or_minus_level_pin_oe,
    input wire logic [7:0] phy_data_in,
    input wire logic [7:0] phy_data_out,
    input wire logic [7:0] phy_data_oe
);
    // ==========================================================
    // Length of the current drive burst
    // ==========================================================
    int busy_cnt;
    int next_busy_cnt;
    always_comb next_busy_cnt = tx_busy ? busy_cnt + 1 : 0;
    always_ff @(posedge sys_clk) busy_cnt <= reset_n ? next_busy_cnt : 0;

    // ==========================================================
    // Properties
    // ==========================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    bus_enable_busy_a: assert property (phy_data_out[0] |-> tx_busy)
        else $error("bus enable high while idle");
    pin_enable_drive_a: assert property (!transmit_output_enable_n |->
        tx_busy && shared_data_or_plus_level_pin_oe && shared_se0_or_minus_level_pin_oe)
        else $error("pin enable without drive");
    single_path_a: assert property (!(phy_data_out[0] && !transmit_output_enable_n))
        else $error("both transmit paths enabled");
    phy_bits_free_a: assert property (phy_data_oe[7:3] == 5'h00)
        else $error("port drives a transceiver bit");
    bus_enable_oe_a: assert property (phy_data_out[0] |-> phy_data_oe[2:0] == 3'h7)
        else $error("bus enable without drive");
    shared_oe_pair_a: assert property (phy_data_oe[1] == phy_data_oe[2])
        else $error("shared bus bits split");
    int_follow_a: assert property (phy_int |-> $past(phy_data_in[3]))
        else $error("interrupt without cause");
    whole_bits_a: assert property ($fell(tx_busy) |->
        busy_cnt >= 2 * BIT_DIV && busy_cnt % BIT_DIV == 0)
        else $error("burst not whole bits");
    bit_hold_a: assert property (tx_busy && $past(tx_busy) &&
        ($changed(shared_data_or_plus_level_pin_out) || $changed(phy_data_out[1])) |->
        busy_cnt % BIT_DIV == 0)
        else $error("data changed inside a bit");
    path_hold_a: assert property (tx_busy && $past(tx_busy) |->
        $stable(transmit_output_enable_n) && $stable(phy_data_out[0]))
        else $error("transmit path switched while busy");
    cover property ($rose(tx_busy));
    cover property ($fell(tx_ready));
    cover property ($rose(phy_int));
endmodule // ufs_port_chk

bind ufs_port ufs_port_chk #(.BIT_DIV(BIT_DIV)) u_chk (
    .sys_clk, .reset_n, .tx_busy, .tx_ready, .phy_int, .transmit_output_enable_n,
    .shared_data_or_plus_level_pin_out, .shared_data_or_plus_level_pin_oe,
    .shared_se0_or_minus_level_pin_oe, .phy_data_in, .phy_data_out, .phy_data_oe
);

// *** testbench/ufs_phy_model.sv ***
// Behavioural model of the external serial transceiver.
`timescale 1ns/1ps
module ufs_phy_model (
    // Line state that the transceiver reports
    input wire logic [7:0] line_state,
    // From the port
    input wire logic [7:0] phy_data_out,
    input wire logic [7:0] phy_data_oe,
    input wire logic shared_data_or_plus_level_pin_out,
    input wire logic shared_data_or_plus_level_pin_oe,
    input wire logic shared_se0_or_minus_level_pin_out,
    input wire logic shared_se0_or_minus_level_pin_oe,
    // Toward the port
    output logic [7:0] phy_data_in,
    output logic shared_data_or_plus_level_pin_in,
    output logic shared_se0_or_minus_level_pin_in,
    output logic buffered_plus_line_input,
    output logic buffered_minus_line_input,
    output logic recv_diff_input
);
    // ==========================================================
    // Wire resolution
    // ==========================================================
    // The port owns a shared line while its enable is up; otherwise the line state returns.
    always_comb begin
        phy_data_in[0] = phy_data_out[0];
        phy_data_in[1] = phy_data_oe[1] ? phy_data_out[1] : line_state[1];
        phy_data_in[2] = phy_data_oe[2] ? phy_data_out[2] : line_state[2];
        phy_data_in[3] = line_state[3];
        phy_data_in[6:4] = line_state[6:4];
        phy_data_in[7] = 1'h0;
        shared_data_or_plus_level_pin_in = shared_data_or_plus_level_pin_oe ?
            shared_data_or_plus_level_pin_out : line_state[1];
        shared_se0_or_minus_level_pin_in = shared_se0_or_minus_level_pin_oe ?
            shared_se0_or_minus_level_pin_out : line_state[2];
        buffered_plus_line_input = line_state[4];
        buffered_minus_line_input = line_state[5];
        recv_diff_input = line_state[6];
    end
endmodule // ufs_phy_model

// *** testbench/usb_full_low_speed_serial_transceiver_port_test.sv ***
// Self-checking testbench for the serial transceiver port.
`timescale 1ns/1ps
module usb_full_low_speed_serial_transceiver_port_test;
    import ufs_pkg::*;
    localparam int BD = 2;
    logic sys_clk = 1'h0;
    logic reset_n = 1'h0;
    ufs_mode_t serial_mode = UFS_DATA_AND_SINGLE_ENDED_ZERO_MODE_BIDIR;
    ufs_map_t bus_map = UFS_MAP_6PIN;
    logic use_data_bus = 1'h0;
    logic tx_valid = 1'h0, tx_last = 1'h0, tx_a = 1'h0, tx_b = 1'h0;
    logic [7:0] line_state = 8'h00;
    logic tx_ready, tx_busy, rx_dat, rx_se0, rx_dp, rx_dm, phy_int, transmit_output_enable_n;
    logic shared_data_or_plus_level_pin_in, shared_data_or_plus_level_pin_out, shared_data_or_plus_level_pin_oe;
    logic shared_se0_or_minus_level_pin_in, shared_se0_or_minus_level_pin_out, shared_se0_or_minus_level_pin_oe;
    logic buffered_plus_line_input, buffered_minus_line_input, recv_diff_input;
    logic [7:0] phy_data_in, phy_data_out, phy_data_oe;
    int err_total = 0, cmp_count = 0, seed = 32'h3a51, refusals = 0;
    logic [3:0] exp_q[$];

    always #5 sys_clk = ~sys_clk;

    ufs_port #(.BIT_DIV(BD)) u_dut (.sys_clk, .reset_n, .serial_mode, .bus_map, .use_data_bus,
        .tx_valid, .tx_ready, .tx_last, .tx_a, .tx_b, .tx_busy, .rx_dat, .rx_se0, .rx_dp, .rx_dm,
        .phy_int, .transmit_output_enable_n, .shared_data_or_plus_level_pin_in,
        .shared_data_or_plus_level_pin_out, .shared_data_or_plus_level_pin_oe,
        .shared_se0_or_minus_level_pin_in, .shared_se0_or_minus_level_pin_out,
        .shared_se0_or_minus_level_pin_oe, .buffered_plus_line_input, .buffered_minus_line_input,
        .recv_diff_input, .phy_data_in, .phy_data_out, .phy_data_oe);

    ufs_phy_model u_phy (.line_state, .phy_data_out, .phy_data_oe, .shared_data_or_plus_level_pin_out,
        .shared_data_or_plus_level_pin_oe, .shared_se0_or_minus_level_pin_out,
        .shared_se0_or_minus_level_pin_oe, .phy_data_in, .shared_data_or_plus_level_pin_in,
        .shared_se0_or_minus_level_pin_in, .buffered_plus_line_input, .buffered_minus_line_input,
        .recv_diff_input);

    // ==========================================================
    // Checking and closing
    // ==========================================================
    task automatic chk(input logic [7:0] e, input logic [7:0] a, input string what);
        cmp_count++;
        if (a !== e) begin
            err_total++;
            $display("Error at %0t: %s is %h, expected %h", $time, what, a, e);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ==========================================================
    // Stimulus
    // ==========================================================
    // Each note is {data, se0, enable, oe} as one bit time should show them.
    task automatic send_pkt(input int n);
        logic a, b, r;
        for (int k = 0; k < n; k++) begin
            a = 1'($random(seed));
            b = 1'($random(seed));
            tx_valid <= 1'h1;
            tx_a <= a;
            tx_b <= b;
            tx_last <= (k == n - 1);
            exp_q.push_back({a, (use_data_bus && serial_mode[1]) ? !a && !b : b, 2'h3});
            do begin
                @(negedge sys_clk);
                r = tx_ready;
                refusals += (r !== 1'h1);
                @(posedge sys_clk);
            end while (r !== 1'h1);
        end
        tx_valid <= 1'h0;
        exp_q.push_back(4'hB);
    endtask

    task automatic wait_idle();
        int t;
        t = 0;
        do begin
            @(negedge sys_clk);
            t++;
        end while ((tx_busy !== 1'h0 || exp_q.size() != 0) && t < 400);
        chk(8'h00, 8'(exp_q.size()), "bits left");
    endtask

    initial begin
        int ph;
        logic [3:0] act;
        ph = 0;
        forever begin
            @(negedge sys_clk);
            if (tx_busy === 1'h1) begin
                if (ph == 0) begin
                    act = use_data_bus ? {phy_data_out[1], phy_data_out[2], phy_data_out[0], phy_data_oe[1]} :
                        {shared_data_or_plus_level_pin_out, shared_se0_or_minus_level_pin_out,
                        !transmit_output_enable_n, shared_data_or_plus_level_pin_oe};
                    if (exp_q.size() == 0) chk(8'h00, 8'hFF, "extra bit");
                    else chk({4'h0, exp_q.pop_front()}, {4'h0, act}, "line bit");
                end
                ph = (ph + 1) % BD;
            end else ph = 0;
        end
    end

    initial begin
        #200000;
        err_total++;
        end_of_test();
    end

    initial begin
        logic [7:0] ls;
        logic [1:0] pp;
        logic lvl;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(8'h03, {4'h0, tx_busy, phy_int, transmit_output_enable_n, tx_ready}, "reset outputs");
        chk(8'h00, phy_data_oe, "reset bus drive");
        @(posedge sys_clk);
        reset_n <= 1'h1;
        // Every mode on the pins, then every mode on the bus, the 3-pin map with modes 1 and 3 only; one long packet overfills the buffer.
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            serial_mode <= ufs_mode_t'(i[1:0]);
            use_data_bus <= i[2];
            bus_map <= ufs_map_t'(i[0]);
            repeat (2) @(posedge sys_clk);
            send_pkt(i == 5 ? 20 : 3 + i);
            // A mode change in mid-packet must not reach the line before idle.
            if (i == 5) serial_mode <= UFS_LEVEL_UNI;
            wait_idle();
            chk(use_data_bus ? (i[0] ? 8'h01 : 8'h07) : {5'h0, i[0], i[0], 1'h1}, use_data_bus ? phy_data_oe :
                {5'h0, shared_data_or_plus_level_pin_oe, shared_se0_or_minus_level_pin_oe,
                transmit_output_enable_n}, "idle drive");
            // Receive in every mode: level pairs come from the shared pins, the buffered inputs or the bus.
            for (int k = 0; k < 4; k++) begin
                @(posedge sys_clk);
                line_state <= 8'($random(seed));
                repeat (3) @(posedge sys_clk);
                @(negedge sys_clk);
                ls = line_state;
                pp = (!use_data_bus && i[1:0] == 2'h2) ? ls[2:1] : ls[5:4];
                lvl = use_data_bus ? !i[0] : (i[1:0] != 2'h0);
                chk({5'h0, lvl ? ls[6] : ls[1], lvl ? !pp[0] && !pp[1] : ls[2], use_data_bus && ls[3]},
                    {5'h0, rx_dat, rx_se0, phy_int}, "receive");
                if (lvl) chk({6'h0, pp[0], pp[1]}, {6'h0, rx_dp, rx_dm}, "levels");
            end
        end
        chk(8'h01, {7'h0, refusals > 0}, "buffer refusal");
        end_of_test();
    end
endmodule // usb_full_low_speed_serial_transceiver_port_test
